// File: core/qtmr_cfg.svh
`ifndef QTMR_CFG_SVH
`define QTMR_CFG_SVH

// Register byte offsets on the APB word map.
`define OFS_RUN 8'h00
`define OFS_CLK 8'h04
`define OFS_MODE 8'h08
`define OFS_TFF 8'h0C
`define OFS_CMP0 8'h10
`define OFS_CMP1 8'h14
`define OFS_CMP2 8'h18
`define OFS_CMP3 8'h1C
`define OFS_LATCH 8'h20
`define OFS_STAT 8'h24

// Field positions.
`define BIT_PRE_RUN 5
`define BIT_TFF_IE 2
`define BIT_TFF_IS 3

// Reset values.
`define RST_RUN 6'h00
`define RST_CLK 8'h00
`define RST_MODE 4'h0
`define RST_CMP 8'h00
`define RST_CMD 2'h3

// Toggle commands.
`define CMD_CLR 2'h0
`define CMD_SET 2'h1
`define CMD_INV 2'h2

// Prescaler: two stages for the quarter rate plus nine more.
`define PRE_W 11
`define TAP8_MSB 2
`define TAP128_MSB 6
`define TAP2048_MSB 10

`endif

// File: core/qtmr_pkg.sv
package qtmr_pkg;

    // Operating mode of a timer pair.
    typedef enum logic [1:0] {
        MODE_8BIT,
        MODE_16BIT,
        MODE_PULSE,
        MODE_PWM
    } pair_mode_e;

    // One-cycle tick enables from the prescaler.
    typedef struct packed {
        logic div8;
        logic div128;
        logic div2048;
    } taps_s;

endpackage

// File: core/interval_counter.sv
`timescale 1ns/100ps

module interval_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic run,
    input wire logic clear,
    input wire logic [7:0] cmp,
    output logic [7:0] count,
    output logic hit,
    output logic carry
);
    logic [7:0] count_q;
    logic [7:0] next_val;

    // The value after this tick; a zero compare meets the wrap to zero, so overflow matches.
    assign next_val = count_q + 8'h01;
    assign hit = run & tick & (next_val == cmp);
    assign carry = run & tick & (count_q == 8'hFF);
    assign count = count_q;

    // A stopped counter is held cleared; a match clears instead of stepping.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 8'h00;
        end else if (!run || clear) begin
            count_q <= 8'h00;
        end else if (tick) begin
            count_q <= next_val;
        end
    end

endmodule // interval_counter

// File: core/quad_interval_timer.sv
// Notes on behaviour
// - Four 8-bit timers, pairs cascade to 16.
// - Timer 2 event count; latch for 2/3.
// - Pair 0/1 pulse mode; timer 1 PWM.
// - Counter plus compare each; shared toggle.
// - Nine-bit prescaler after quarter-rate stage.
// - Taps every 8, 128, 2048 clocks.
// - Prescaler run bit; zero clears and stops.
// - Prescaler run bit resets to zero.
// - Lower timer tick chosen; code 01 divides 8.
// - 16-bit mode: lower carry ticks upper.
// - Otherwise upper picks tap or lower match.
// - Mode 01 cascades; mode 00 is 8-bit.
// - Both pair modes reset to 8-bit.
// - Per timer count, stop or clear.
// - Reset clears counters and stops timers.
// - Match when counter equals compare value.
// - Compare zero matches on counter overflow.
// - Compare writes act at once.
// - Compare 0 and 1 read back zero.
// - Compare 2/3 write; reads give latch.
// - Match raises timer request; clears counter in 8-bit mode.
// - Toggle command: 00 clear, 01 set, 10 invert.
// - Low compare write disarms until high written.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "qtmr_cfg.svh"

module quad_interval_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_pin,
    output logic [3:0] timer_match_irq,
    output logic toggle_out
);

    // Register state.
    logic [5:0] run_control_reg_q;
    logic [7:0] clock_select_reg_q;
    logic [3:0] pair_mode_reg_q;
    logic tff_ie_q;
    logic tff_is_q;
    logic [7:0] cmp_q [4];
    logic [7:0] latch_q [2];
    logic [1:0] armed_q;
    logic pair_low_toggle_ff_q;

    // Bus outputs.
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic [3:0] irq_q;

    // Internal signals.
    logic access;
    logic wr_en;
    logic [2:0] evt_sync_q;
    logic evt_edge;
    logic [`PRE_W-1:0] pre_q;
    qtmr_pkg::taps_s taps;
    logic [3:0] tick;
    logic [3:0] hit;
    logic [3:0] carry;
    logic [3:0] match;
    logic [3:0] clear;
    logic [7:0] cnt [4];
    logic [1:0] is16;
    qtmr_pkg::pair_mode_e low_mode;
    logic pulse_mode;
    logic pwm_mode;
    logic hw_invert;

    // Address decode for the error answer only; the read mux decodes paddr with its own case.
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a <= `OFS_STAT) && (a[1:0] == 2'h0);
    endfunction

    // Tick choice per timer; code 00 takes the alternate source.
    function automatic logic pick_tick(input logic [1:0] code, input logic alt, input qtmr_pkg::taps_s t);
        unique case (code)
            2'h0: pick_tick = alt;
            2'h1: pick_tick = t.div8;
            2'h2: pick_tick = t.div128;
            2'h3: pick_tick = t.div2048;
        endcase
    endfunction

    assign access = psel & penable;
    assign wr_en = access & pwrite & pready_q;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign timer_match_irq = irq_q;
    assign toggle_out = pair_low_toggle_ff_q;

    // The event pin is asynchronous; only the second and third stages feed the edge detector.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_sync_q <= 3'h0;
        end else begin
            evt_sync_q <= {evt_sync_q[1:0], event_pin};
        end
    end

    assign evt_edge = evt_sync_q[1] & ~evt_sync_q[2];

    // Prescaler: low two bits give the quarter rate, the upper nine divide further.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else if (!run_control_reg_q[`BIT_PRE_RUN]) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 11'h001;
        end
    end

    // Taps are single-cycle enables, so every timer stays in the one clock domain.
    always_comb begin
        taps.div8 = run_control_reg_q[`BIT_PRE_RUN] & (&pre_q[`TAP8_MSB:0]);
        taps.div128 = run_control_reg_q[`BIT_PRE_RUN] & (&pre_q[`TAP128_MSB:0]);
        taps.div2048 = run_control_reg_q[`BIT_PRE_RUN] & (&pre_q[`TAP2048_MSB:0]);
    end

    // Pair modes.
    assign is16[0] = (pair_mode_reg_q[1:0] == 2'h1);
    assign is16[1] = (pair_mode_reg_q[3:2] == 2'h1);
    assign low_mode = qtmr_pkg::pair_mode_e'(pair_mode_reg_q[1:0]);
    assign pulse_mode = (low_mode == qtmr_pkg::MODE_PULSE);
    assign pwm_mode = (low_mode == qtmr_pkg::MODE_PWM);

    // Tick routing; timer 0 has no alternate source, timer 2 counts pin events.
    always_comb begin
        tick[0] = pick_tick(clock_select_reg_q[1:0], 1'b0, taps);
        tick[2] = pick_tick(clock_select_reg_q[5:4], evt_edge, taps);
        if (is16[0]) begin
            tick[1] = carry[0];
        end else begin
            tick[1] = pick_tick(clock_select_reg_q[3:2], hit[0], taps);
        end
        if (is16[1]) begin
            tick[3] = carry[2];
        end else begin
            tick[3] = pick_tick(clock_select_reg_q[7:6], hit[2], taps);
        end
    end

    // Four independent counters with their comparators.
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_tmr
            interval_counter u_cnt (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick[i]),
                .run(run_control_reg_q[i]),
                .clear(clear[i]),
                .cmp(cmp_q[i]),
                .count(cnt[i]),
                .hit(hit[i]),
                .carry(carry[i])
            );
        end
    endgenerate

    // Match and clear per pair. In 16-bit mode the pair matches only when both halves agree,
    // and a low-byte write holds the comparator off until the high byte lands.
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pair
            logic [7:0] hi_next;
            logic armed;
            logic m16;
            logic pulse_here;
            logic pwm_here;

            assign hi_next = cnt[2*p+1] + {7'h00, carry[2*p]};
            assign armed = ~is16[p] | armed_q[p];
            assign m16 = hit[2*p] & armed & (hi_next == cmp_q[2*p+1]);
            assign pulse_here = (p == 0) && pulse_mode;
            assign pwm_here = (p == 0) && pwm_mode;

            assign match[2*p] = hit[2*p] & armed;
            assign match[2*p+1] = is16[p] ? m16 : hit[2*p+1];

            // In pulse mode the upper match ends the cycle for both counters.
            assign clear[2*p] = is16[p] ? m16 : (pulse_here ? match[2*p+1] : match[2*p]);
            assign clear[2*p+1] = match[2*p+1] & ~pwm_here;
        end
    endgenerate

    // Interrupt requests are one-cycle pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 4'h0;
        end else begin
            irq_q <= match;
        end
    end

    // Hardware inversion source follows the pair mode.
    always_comb begin
        if (pulse_mode) begin
            hw_invert = match[0] | match[1];
        end else if (pwm_mode) begin
            hw_invert = match[1] | carry[1];
        end else if (is16[0] || tff_is_q) begin
            hw_invert = match[1];
        end else begin
            hw_invert = match[0];
        end
    end

    // Shared toggle flip-flop. A software command wins over a match in the same cycle,
    // since software expects the state it wrote.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_low_toggle_ff_q <= 1'b0;
        end else if (wr_en && paddr == `OFS_TFF && pwdata[1:0] != `RST_CMD) begin
            unique case (pwdata[1:0])
                `CMD_CLR: pair_low_toggle_ff_q <= 1'b0;
                `CMD_SET: pair_low_toggle_ff_q <= 1'b1;
                default: pair_low_toggle_ff_q <= ~pair_low_toggle_ff_q;
            endcase
        end else if (tff_ie_q && hw_invert) begin
            pair_low_toggle_ff_q <= ~pair_low_toggle_ff_q;
        end
    end

    // Control registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_control_reg_q <= `RST_RUN;
            clock_select_reg_q <= `RST_CLK;
            pair_mode_reg_q <= `RST_MODE;
            tff_ie_q <= 1'b0;
            tff_is_q <= 1'b0;
        end else if (wr_en) begin
            if (paddr == `OFS_RUN) begin
                run_control_reg_q <= pwdata[5:0];
            end
            if (paddr == `OFS_CLK) begin
                clock_select_reg_q <= pwdata[7:0];
            end
            if (paddr == `OFS_MODE) begin
                pair_mode_reg_q <= pwdata[3:0];
            end
            if (paddr == `OFS_TFF) begin
                tff_ie_q <= pwdata[`BIT_TFF_IE];
                tff_is_q <= pwdata[`BIT_TFF_IS];
            end
        end
    end

    // Compare registers take effect on the next cycle's comparison.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < 4; k++) begin
                cmp_q[k] <= `RST_CMP;
            end
        end else if (wr_en) begin
            for (int k = 0; k < 4; k++) begin
                if (paddr == `OFS_CMP0 + 8'(4 * k)) begin
                    cmp_q[k] <= pwdata[7:0];
                end
            end
        end
    end

    // Comparator arming: the low byte disarms a 16-bit pair, the high byte rearms it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 2'h3;
        end else if (wr_en) begin
            if (paddr == `OFS_CMP0 && is16[0]) begin
                armed_q[0] <= 1'b0;
            end
            if (paddr == `OFS_CMP1) begin
                armed_q[0] <= 1'b1;
            end
            if (paddr == `OFS_CMP2 && is16[1]) begin
                armed_q[1] <= 1'b0;
            end
            if (paddr == `OFS_CMP3) begin
                armed_q[1] <= 1'b1;
            end
        end
    end

    // Software latch snapshots both counters together so a 16-bit value stays coherent.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q[0] <= 8'h00;
            latch_q[1] <= 8'h00;
        end else if (wr_en && paddr == `OFS_LATCH) begin
            latch_q[0] <= cnt[2];
            latch_q[1] <= cnt[3];
        end
    end

    // Read mux; compare 0 and 1 cannot be read back.
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            `OFS_RUN: rd_d[5:0] = run_control_reg_q;
            `OFS_CLK: rd_d[7:0] = clock_select_reg_q;
            `OFS_MODE: rd_d[3:0] = pair_mode_reg_q;
            `OFS_TFF: rd_d[3:0] = {tff_is_q, tff_ie_q, `RST_CMD};
            `OFS_CMP0: rd_d = 32'h0000_0000;
            `OFS_CMP1: rd_d = 32'h0000_0000;
            `OFS_CMP2: rd_d[7:0] = latch_q[0];
            `OFS_CMP3: rd_d[7:0] = latch_q[1];
            `OFS_STAT: rd_d[2:0] = {armed_q, pair_low_toggle_ff_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // One wait state: data and error are registered in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (access && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= ~addr_mapped(paddr);
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

endmodule // quad_interval_timer

// File: verif/qtmr_properties.sv
`timescale 1ns/100ps

module qtmr_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic event_pin,
    input wire logic [3:0] timer_match_irq,
    input wire logic toggle_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic pre_run_q;
    logic wr_done;
    logic tff_wr;

    // A write counts only at the edge where the slave completes it.
    assign wr_done = psel && penable && pready && pwrite;
    assign tff_wr = wr_done && paddr == 8'h0C;

    // Mirror of the prescaler run bit; timers 0 and 1 have no tick source without it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_run_q <= 1'b0;
        end else if (wr_done && paddr == 8'h00) begin
            pre_run_q <= pwdata[5];
        end
    end

    toggle_clear_a: assert property (tff_wr && pwdata[1:0] == 2'h0 |=> !toggle_out)
        else $error("toggle not cleared by command");
    toggle_set_a: assert property (tff_wr && pwdata[1:0] == 2'h1 |=> toggle_out)
        else $error("toggle not set by command");
    toggle_invert_a: assert property (tff_wr && pwdata[1:0] == 2'h2 |=> toggle_out != $past(toggle_out))
        else $error("toggle not inverted by command");
    prescaler_halt_a: assert property (!pre_run_q && !$past(pre_run_q) |-> timer_match_irq[1:0] == 2'h0)
        else $error("timer request while prescaler stopped");
    cmp_hidden_a: assert property (pready && !pwrite && paddr[7:3] == 5'h02 |-> prdata == 32'h0)
        else $error("compare register readable");
    irq_spacing_a: assert property (timer_match_irq[0] |=> !timer_match_irq[0] [*7])
        else $error("timer 0 requests closer than the fastest tap");
    irq_pulse_a: assert property (timer_match_irq != 4'h0 |=> (timer_match_irq & $past(timer_match_irq)) == 4'h0)
        else $error("timer request held longer than one cycle");
    ready_pulse_a: assert property (pready |-> psel && penable && $past(psel && penable) ##1 !pready)
        else $error("ready outside a single access cycle");
    unmapped_error_a: assert property (pready && (paddr > 8'h24 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
endmodule // qtmr_properties

// File: verif/quad_eight_bit_interval_timers_test.sv
`timescale 1ns/100ps
`include "qtmr_cfg.svh"

module quad_eight_bit_interval_timers_test;
    logic pclk, presetn, psel, penable, pwrite, event_pin, pready, pslverr, toggle_out, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] timer_match_irq;
    int bad_count, checked, cyc, irq_n;
    int tap[4] = '{0, 8, 128, 2048};
    logic [1:0] cmds[4] = '{2'h1, 2'h2, 2'h2, 2'h0};

    quad_interval_timer quad_interval_timer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .event_pin, .timer_match_irq, .toggle_out);

    // The bench clock; the design takes it as the oscillator too.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Cycle count and timer 0 request count, for period and silence checks.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (timer_match_irq[0] === 1'b1) irq_n <= irq_n + 1;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(32'(n < 20), 32'h1);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Measures the gap between two requests of one timer, in clocks.
    task period(input int b, input int exp);
        int t;
        int n;
        for (int k = 0; k < 2; k++) begin
            t = cyc;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (timer_match_irq[b] !== 1'b1 && n < 9000);
        end
        check(32'(cyc - t), 32'(exp));
    endtask

    task test_reset;
        check(32'(toggle_out), 32'h0);
        rdchk(`OFS_RUN, 32'h0);
        rdchk(`OFS_CLK, 32'h0);
        rdchk(`OFS_MODE, 32'h0);
        rdchk(`OFS_STAT, 32'h6);
        rdchk(`OFS_TFF, 32'h3);
    endtask

    task test_bus;
        wr(`OFS_CMP0, 32'h5A);
        rdchk(`OFS_CMP0, 32'h0);
        rdchk(`OFS_CMP1, 32'h0);
        rdchk(8'h28, 32'h0);
        check(32'(err), 32'h1);
        wr(8'h2C, 32'h1);
        check(32'(err), 32'h1);
    endtask

    // Timer 0 set running while the prescaler stays off must stay silent.
    task test_taps;
        int n0;
        wr(`OFS_CMP0, 32'h1);
        wr(`OFS_CLK, 32'h1);
        wr(`OFS_RUN, 32'h1);
        n0 = irq_n;
        repeat (64) @(posedge pclk);
        check(32'(irq_n - n0), 32'h0);
        for (int c = 1; c < 4; c++) begin
            wr(`OFS_RUN, 32'h0);
            wr(`OFS_CLK, 32'(c));
            wr(`OFS_CMP0, 32'h2);
            wr(`OFS_RUN, 32'h21);
            period(0, 2 * tap[c]);
        end
        wr(`OFS_CMP0, 32'h3);
        period(0, 3 * 2048);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_CLK, 32'h1);
        wr(`OFS_CMP0, 32'h0);
        wr(`OFS_RUN, 32'h21);
        period(0, 256 * 8);
    endtask

    task test_chain;
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_CLK, 32'h11);
        wr(`OFS_CMP0, 32'h2);
        wr(`OFS_CMP1, 32'h3);
        wr(`OFS_CMP2, 32'h5);
        wr(`OFS_CMP3, 32'h2);
        wr(`OFS_RUN, 32'h2F);
        period(1, 48);
        period(3, 80);
        period(2, 40);
    endtask

    // Upper clock select stays at the timer 0 match code, which cascade mode must ignore.
    task test_cascade;
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_MODE, 32'h1);
        wr(`OFS_CLK, 32'h1);
        wr(`OFS_CMP0, 32'h4);
        rdchk(`OFS_STAT, 32'h4);
        wr(`OFS_CMP1, 32'h1);
        rdchk(`OFS_STAT, 32'h6);
        wr(`OFS_RUN, 32'h23);
        period(1, 260 * 8);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_MODE, 32'h0);
    endtask

    // Toggle holds for hold clocks after an edge, then inverts at the next one.
    task duty(input int hold);
        logic last;
        last = toggle_out;
        repeat (hold - 1) @(posedge pclk);
        check(32'(toggle_out), 32'(last));
        @(posedge pclk);
        check(32'(toggle_out), 32'(!last));
    endtask

    // Hardware inversion: timer 1 drives a square wave, then pulse mode of pair 0/1; PWM mode checks only the timer 1 period.
    // Pulse mode shows both edges, so a wrong clear source changes the duty as well as the cycle.
    task test_wave;
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_CLK, 32'h5);
        wr(`OFS_CMP0, 32'h2);
        wr(`OFS_CMP1, 32'h3);
        wr(`OFS_TFF, 32'hC);
        rdchk(`OFS_TFF, 32'hF);
        wr(`OFS_RUN, 32'h22);
        period(1, 24);
        duty(24);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_CMP1, 32'h5);
        wr(`OFS_MODE, 32'h2);
        wr(`OFS_RUN, 32'h23);
        period(0, 40);
        duty(24);
        duty(16);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_MODE, 32'h3);
        wr(`OFS_RUN, 32'h22);
        period(1, 256 * 8);
        wr(`OFS_RUN, 32'h0);
        wr(`OFS_MODE, 32'h0);
    endtask

    task test_toggle;
        logic exp;
        exp = 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(`OFS_TFF, 32'(cmds[k]));
            exp = (cmds[k] == 2'h2) ? !exp : cmds[k][0];
            @(posedge pclk);
            check(32'(toggle_out), 32'(exp));
        end
    endtask

    // Event edges count with the prescaler off, then a latch freezes the count.
    task test_latch;
        wr(`OFS_CLK, 32'h0);
        wr(`OFS_CMP2, 32'h0);
        wr(`OFS_RUN, 32'h4);
        repeat (5) begin
            @(posedge pclk);
            event_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            event_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        wr(`OFS_LATCH, 32'h0);
        rdchk(`OFS_CMP2, 32'h5);
        rdchk(`OFS_CMP3, 32'h0);
    endtask

    task stop_test;
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, event_pin, presetn} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        test_reset;
        test_bus;
        test_taps;
        test_chain;
        test_cascade;
        test_wave;
        test_toggle;
        test_latch;
        stop_test;
    end

    // The longest waits are a few periods of the slowest tap; this leaves ample margin.
    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        stop_test;
    end
endmodule // quad_eight_bit_interval_timers_test

bind quad_interval_timer qtmr_properties qtmr_properties_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .event_pin, .timer_match_irq, .toggle_out);
